// [spc_dev_model.sv]
`timescale 1ns/1ns
module spc_dev_model import spc_pkg::*; #(
	parameter int RD_PRE = 2,
	parameter int WR_PRE = 8
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Command pins
	input wire spc_pkg::spc_pins_t pins_in,
	// Device state and timing faults seen
	output logic [spc_pkg::NUM_BANKS-1:0] open_out,
	output int viol_out
);
	int act_a[NUM_BANKS], pre_a[NUM_BANKS], rd_a[NUM_BANKS], wr_a[NUM_BANKS], ap_t[NUM_BANKS];
	logic [1:0] b;
	logic a10;
	assign b = {pins_in.bank_sel_hi, pins_in.bank_sel_lo};
	assign a10 = pins_in.addr[AP_BIT_POS];
	// Per-bank ages; faults only counted, the bench judges the total
	always @(posedge ref_clk_in) begin
		for (int i = 0; i < NUM_BANKS; i++) begin
			act_a[i] = rst_in ? 99 : act_a[i] + 1;
			pre_a[i] = rst_in ? 99 : pre_a[i] + 1;
			rd_a[i] = rst_in ? 99 : rd_a[i] + 1;
			wr_a[i] = rst_in ? 99 : wr_a[i] + 1;
			if (rst_in) ap_t[i] = -1;
			else if (ap_t[i] > 1) ap_t[i]--;
			else if (ap_t[i] == 1 && act_a[i] >= RAS_CYC) begin
				open_out[i] = 1'b0;
				pre_a[i] = 0;
				ap_t[i] = -1;
			end
		end
		if (rst_in) begin
			open_out = '0;
			viol_out = 0;
		end else if (!pins_in.cs_n) case ({pins_in.ras_n, pins_in.cas_n, pins_in.we_n})
			3'h3: begin
				if (open_out[b] || pre_a[b] < RP_CYC || act_a[b] < RC_CYC) viol_out++;
				open_out[b] = 1'b1;
				act_a[b] = 0;
			end
			3'h4, 3'h5: begin
				if (!open_out[b]) viol_out++;
				if (pins_in.we_n) rd_a[b] = 0;
				else wr_a[b] = 0;
				if (a10) ap_t[b] = pins_in.we_n ? RD_PRE : WR_PRE;
			end
			3'h2: for (int i = 0; i < NUM_BANKS; i++) if (a10 || i == b) begin
				if (open_out[i] && (act_a[i] < RAS_CYC || rd_a[i] < RD_PRE || wr_a[i] < WR_PRE)) viol_out++;
				open_out[i] = 1'b0;
				pre_a[i] = 0;
			end
			default: ;
		endcase
	end
endmodule // spc_dev_model

// [spc_pkg.sv]
package spc_pkg;
	// ----------------------------------------
	// Clock and analog timing
	// ----------------------------------------
	localparam int TCK_NS = 10;
	localparam int T_RP_NS = 15;
	localparam int T_RAS_NS = 45;
	localparam int T_RC_NS = 60;
	localparam int T_RTP_NS = 8;
	localparam int T_WR_NS = 15;
	// Least times round up to whole cycles
	localparam int RP_CYC = (T_RP_NS + TCK_NS - 1) / TCK_NS;
	localparam int RAS_CYC = (T_RAS_NS + TCK_NS - 1) / TCK_NS;
	localparam int RC_CYC = (T_RC_NS + TCK_NS - 1) / TCK_NS;
	localparam int RTP_CYC = (T_RTP_NS + TCK_NS - 1) / TCK_NS;
	localparam int WR_CYC = (T_WR_NS + TCK_NS - 1) / TCK_NS;
	// Internal auto-precharge never earlier than this after last prefetch
	localparam int AP_MIN_GAP = 2;

	// ----------------------------------------
	// Widths and field positions
	// ----------------------------------------
	localparam int CNT_W = 8;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ADDR_W = 14;
	localparam int AP_BIT_POS = 10;

	// ----------------------------------------
	// Commands and carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		SPC_NOP = 3'b000,
		SPC_ACT = 3'b001,
		SPC_RD = 3'b010,
		SPC_WR = 3'b011,
		SPC_PRE = 3'b100,
		SPC_PREA = 3'b101
	} spc_cmd_t;

	typedef struct packed {
		spc_cmd_t cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic auto_pre;
	} spc_req_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic bank_sel_hi;
		logic bank_sel_lo;
		logic [ADDR_W-1:0] addr;
	} spc_pins_t;

	typedef struct packed {
		logic open;
		logic ap_pend;
		logic [CNT_W-1:0] ras_cnt;
		logic [CNT_W-1:0] rc_cnt;
		logic [CNT_W-1:0] pre_cnt;
		logic [CNT_W-1:0] act_cnt;
		logic [CNT_W-1:0] ap_cnt;
	} spc_bank_t;

	localparam spc_pins_t PINS_DESELECT = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
		bank_sel_hi: 1'b0, bank_sel_lo: 1'b0, addr: '0};
	localparam spc_bank_t BANK_RESET = '{open: 1'b0, ap_pend: 1'b0, ras_cnt: '0, rc_cnt: '0,
		pre_cnt: '0, act_cnt: '0, ap_cnt: '0};
endpackage

// [spc_precharge_ctrl.sv]
`timescale 1ns/1ns
// Notes on behaviour
// [R1] Precharge drives chip select, row strobe, write enable low, column strobe high.
// [R2] Auto-precharge bit high closes all banks; low closes the bank selected.
// [R3] Read to precharge spacing is AL + BL/2 + max(READ_TO_PRECHARGE_CYCLES,2) - 2 clocks.
// [R4] Earliest precharge after read is AL + BL/2 clocks.
// [R5] Activate waits precharge period after precharge of that bank.
// [R6] No precharge before row active minimum time since activation.
// [R7] Read to precharge time counts from last 4-bit prefetch edge.
// [R8] Write to precharge spacing is WL + BL/2 + write recovery cycles.
// [R9] Precharge never interrupts write burst or recovery; recovery is analog time.
// [R10] Auto-precharge bit low keeps bank open; high closes it after burst.
// [R11] Read auto-precharge starts AL + BL/2 later, delayed by lockout and READ_TO_PRECHARGE_CYCLES.
// [R12] Delayed internal precharge starts the precharge period at that point.
// [R13] Internal auto-precharge not earlier than two clocks after final prefetch.
// [R14] Reactivate after read auto-precharge needs precharge period and row cycle time.
// [R15] Write auto-precharge starts after burst plus recovery; reactivate then after period.
// [R16] Row lockout delays auto-precharge until row active minimum time met.
// [R17] Precharge commands are at least one clock apart.
// [R18] READ_TO_PRECHARGE_CYCLES cycles are read-to-precharge time over clock period, rounded up.
// [R19] Precharge period counts from latest precharge of either kind to bank.
// [R20] A different row needs the open bank closed first.
// [R21] Read latency is AL + CL; write latency one clock less.
// [R22] Open state and timers are kept per bank.
module spc_precharge_ctrl #(
	parameter int ADD_LAT = 0,
	parameter int CAS_LAT = 5,
	parameter int BURST_LEN = 4
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// User command port
	input wire logic req_valid_in,
	input wire spc_pkg::spc_req_t req_in,
	output logic req_ready_out,
	// Memory command pins
	output spc_pkg::spc_pins_t pins_out,
	// Status
	output logic [spc_pkg::NUM_BANKS-1:0] bank_open_out
);
	import spc_pkg::*;

	// ----------------------------------------
	// Derived command spacing in cycles
	// ----------------------------------------
	localparam int WRITE_LAT = ADD_LAT + CAS_LAT - 1; // R21
	localparam int RTP_EFF = (RTP_CYC > AP_MIN_GAP) ? RTP_CYC : AP_MIN_GAP; // R13 R18
	localparam int RD2PRE_I = ADD_LAT + BURST_LEN / 2 + RTP_EFF - 2; // R3 R4 R7
	localparam int WR2PRE_I = WRITE_LAT + BURST_LEN / 2 + WR_CYC; // R8 R9
	localparam logic [CNT_W-1:0] RD2PRE = CNT_W'(RD2PRE_I);
	localparam logic [CNT_W-1:0] WR2PRE = CNT_W'(WR2PRE_I);
	localparam logic [CNT_W-1:0] RP_N = CNT_W'(RP_CYC);
	localparam logic [CNT_W-1:0] RP_AP = CNT_W'(RP_CYC - 1);
	localparam logic [CNT_W-1:0] RAS_N = CNT_W'(RAS_CYC);
	localparam logic [CNT_W-1:0] RC_N = CNT_W'(RC_CYC);
	// Counters release a command one edge after they reach zero, so explicit spacings
	// run a clock long: that costs bandwidth but never lets a command in early

	// Registered shadow of each bank, plus the next values from the bank logic
	spc_bank_t bank [NUM_BANKS];
	spc_bank_t next_bank [NUM_BANKS];
	spc_pins_t next_pins;
	logic issue;
	logic [NUM_BANKS-1:0] pre_ok;
	logic all_pre_ok;

	// ----------------------------------------
	// Admission check
	// ----------------------------------------
	// Precharge is safe only after lockout and read/write spacing
	always_comb begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			pre_ok[b] = (bank[b].ras_cnt == '0) && (bank[b].pre_cnt == '0) && !bank[b].ap_pend; // R6 R3 R8
		end
		all_pre_ok = &pre_ok;
	end

	// Ready is combinational so a legal request issues this cycle
	always_comb begin
		spc_bank_t t;
		t = bank[req_in.bank];
		case (req_in.cmd)
			SPC_NOP: req_ready_out = 1'b1;
			// Activate needs a closed bank, precharge period and row cycle done
			SPC_ACT: req_ready_out = !t.open && !t.ap_pend && t.act_cnt == '0 && t.rc_cnt == '0; // R5 R14 R20
			SPC_RD: req_ready_out = t.open && !t.ap_pend;
			SPC_WR: req_ready_out = t.open && !t.ap_pend;
			SPC_PRE: req_ready_out = pre_ok[req_in.bank]; // R6 R9
			SPC_PREA: req_ready_out = all_pre_ok; // R3 R8
			default: req_ready_out = 1'b0;
		endcase
	end

	// A refused request is simply held by the user; nothing is queued here
	assign issue = req_valid_in && req_ready_out;

	// ----------------------------------------
	// Pin encoding
	// ----------------------------------------
	// One command per clock, so two precharges are always a clock apart
	always_comb begin
		next_pins = PINS_DESELECT; // R17
		if (issue && req_in.cmd != SPC_NOP) begin
			next_pins.cs_n = 1'b0;
			next_pins.bank_sel_hi = req_in.bank[1];
			next_pins.bank_sel_lo = req_in.bank[0];
			next_pins.addr = req_in.addr;
			case (req_in.cmd)
				SPC_ACT: begin
					next_pins.ras_n = 1'b0;
				end
				SPC_RD: begin
					next_pins.cas_n = 1'b0;
					next_pins.addr[AP_BIT_POS] = req_in.auto_pre; // R10
				end
				SPC_WR: begin
					next_pins.cas_n = 1'b0;
					next_pins.we_n = 1'b0;
					next_pins.addr[AP_BIT_POS] = req_in.auto_pre; // R10
				end
				SPC_PRE: begin
					next_pins.ras_n = 1'b0; // R1
					next_pins.we_n = 1'b0;
					next_pins.addr[AP_BIT_POS] = 1'b0; // R2
				end
				SPC_PREA: begin
					next_pins.ras_n = 1'b0; // R1
					next_pins.we_n = 1'b0;
					next_pins.addr[AP_BIT_POS] = 1'b1; // R2
				end
				default: begin
					next_pins.cs_n = 1'b1;
				end
			endcase
		end
	end

	// Registered pins give the device clean command levels for a whole cycle
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pins_out <= PINS_DESELECT;
		end else begin
			pins_out <= next_pins;
		end
	end

	// ----------------------------------------
	// Per-bank model of the device state
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : gen_bank
			// Shadow of the device timers so issue never violates them
			always_comb begin
				spc_bank_t n;
				logic hit;
				n = bank[g];
				hit = issue && (req_in.bank == BANK_W'(g));
				// Down-counters saturate at zero
				if (n.ras_cnt != '0) n.ras_cnt = n.ras_cnt - 1'b1;
				if (n.rc_cnt != '0) n.rc_cnt = n.rc_cnt - 1'b1;
				if (n.pre_cnt != '0) n.pre_cnt = n.pre_cnt - 1'b1;
				if (n.act_cnt != '0) n.act_cnt = n.act_cnt - 1'b1;
				if (n.ap_cnt != '0) n.ap_cnt = n.ap_cnt - 1'b1;
				// Internal precharge starts when lockout and spacing both expire; the shadow
				// leads the device by one edge, as for explicit commands, so it closes one edge early
				if (bank[g].ap_pend && bank[g].ap_cnt <= CNT_W'(1)) begin
					n.open = 1'b0; // R10 R15
					n.ap_pend = 1'b0;
					n.act_cnt = RP_AP; // R12 R14
				end
				if (hit) begin
					case (req_in.cmd)
						SPC_ACT: begin
							n.open = 1'b1; // R22
							n.ras_cnt = RAS_N; // R6
							n.rc_cnt = RC_N; // R14
						end
						SPC_RD: begin
							if (n.pre_cnt < RD2PRE) n.pre_cnt = RD2PRE; // R3
							// Auto-precharge waits for the later of lockout end and read spacing
							if (req_in.auto_pre) begin
								n.ap_pend = 1'b1; // R11
								n.ap_cnt = (n.ras_cnt > RD2PRE) ? n.ras_cnt : RD2PRE; // R11 R16
							end
						end
						SPC_WR: begin
							if (n.pre_cnt < WR2PRE) n.pre_cnt = WR2PRE; // R8
							// Write auto-precharge waits for the later of burst end plus recovery and lockout end
							if (req_in.auto_pre) begin
								n.ap_pend = 1'b1;
								n.ap_cnt = (n.ras_cnt > WR2PRE) ? n.ras_cnt : WR2PRE; // R15 R16
							end
						end
						SPC_PRE: begin
							n.open = 1'b0; // R2
							n.act_cnt = RP_N; // R5 R19
						end
						default: begin
						end
					endcase
				end
				if (issue && req_in.cmd == SPC_PREA) begin
					n.open = 1'b0; // R2
					n.act_cnt = RP_N; // R19
				end
				next_bank[g] = n;
			end

			// Only registers the next state worked out above
			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					bank[g] <= BANK_RESET;
				end else begin
					bank[g] <= next_bank[g];
				end
			end

			// Status follows the shadow, one edge ahead of the device itself
			assign bank_open_out[g] = bank[g].open;
		end
	endgenerate
endmodule // spc_precharge_ctrl

// [spc_precharge_ctrl_chk.sv]
`timescale 1ns/1ns
module spc_chk import spc_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Watched ports
	input wire logic req_valid_in,
	input wire spc_pkg::spc_req_t req_in,
	input wire logic req_ready_out,
	input wire spc_pkg::spc_pins_t pins_out,
	input wire logic [spc_pkg::NUM_BANKS-1:0] bank_open_out
);
	logic tk;
	// Request taken on this edge
	assign tk = req_valid_in && req_ready_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// ----
	// Command checks
	// ----
	a_pre_pins: assert property (tk && req_in.cmd == SPC_PRE |=>
		{pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n, pins_out.addr[AP_BIT_POS]} == 5'h04)
		else $error("precharge pins wrong");
	a_prea_all: assert property (tk && req_in.cmd == SPC_PREA |=>
		pins_out.addr[AP_BIT_POS] && bank_open_out == 4'h0) else $error("precharge all failed");
	a_pre_bank: assert property (tk && req_in.cmd == SPC_PRE |=>
		{pins_out.bank_sel_hi, pins_out.bank_sel_lo} == $past(req_in.bank) && !bank_open_out[$past(req_in.bank)])
		else $error("precharge bank wrong");
	a_act_open: assert property (tk && req_in.cmd == SPC_ACT |=> bank_open_out[$past(req_in.bank)])
		else $error("bank not open");
	a_act_rp: assert property (tk && req_in.cmd == SPC_PRE ##1 req_valid_in && req_in.cmd == SPC_ACT &&
		req_in.bank == $past(req_in.bank) |-> !req_ready_out) else $error("activate inside precharge period");
	a_act_ras: assert property (tk && req_in.cmd == SPC_ACT ##1 req_valid_in && req_in.cmd == SPC_PRE &&
		req_in.bank == $past(req_in.bank) |-> !req_ready_out) else $error("precharge inside lockout");
	a_rd_gap: assert property (tk && (req_in.cmd == SPC_PREA || req_in.cmd == SPC_PRE &&
		req_in.bank == $past(req_in.bank)) |-> !$past(tk && req_in.cmd == SPC_RD)) else $error("read spacing broken");
	a_rd_pins: assert property (tk && req_in.cmd == SPC_RD |=>
		{pins_out.ras_n, pins_out.cas_n, pins_out.we_n, pins_out.addr[AP_BIT_POS]} == {3'h5, $past(req_in.auto_pre)})
		else $error("read pins wrong");
	a_idle_desel: assert property (!tk |=> pins_out.cs_n) else $error("pins not deselected");
	// Main scenarios reached
	c_prea: cover property (tk && req_in.cmd == SPC_PREA);
	c_rd_ap: cover property (tk && req_in.cmd == SPC_RD && req_in.auto_pre);
	c_wr: cover property (tk && req_in.cmd == SPC_WR);
endmodule // spc_chk
bind spc_precharge_ctrl spc_chk chk_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
	.req_in(req_in), .req_ready_out(req_ready_out), .pins_out(pins_out), .bank_open_out(bank_open_out));

// [spc_precharge_ctrl_tb.sv]
`timescale 1ns/1ns
module spc_precharge_ctrl_tb;
	import spc_pkg::*;
	localparam int RD_PRE = 4 / 2 + ((RTP_CYC > 2) ? RTP_CYC : 2) - 2;
	localparam int WR_PRE = 5 - 1 + 4 / 2 + WR_CYC;
	logic ref_clk_in = 0, rst_in = 1, req_valid_in = 0, req_ready_out, tkn;
	spc_req_t req_in = '0;
	spc_pins_t pins_out;
	logic [NUM_BANKS-1:0] bank_open_out, open_d, mdl_open;
	int viol, fail_count = 0, cmp_count = 0, cyc = 0, seed = 76966;
	spc_precharge_ctrl #(.ADD_LAT(0), .CAS_LAT(5), .BURST_LEN(4)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out), .pins_out(pins_out),
		.bank_open_out(bank_open_out));
	spc_dev_model #(.RD_PRE(RD_PRE), .WR_PRE(WR_PRE)) mdl_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.pins_in(pins_out), .open_out(mdl_open), .viol_out(viol));
	// ----
	// Helpers
	// ----
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Row address and don't-care bank bits masked out
	function automatic logic [7:0] view(spc_pins_t p, spc_cmd_t c);
		return {1'b0, p.cs_n, p.ras_n, p.cas_n, p.we_n, (c == SPC_PREA) ? 2'h0 : {p.bank_sel_hi, p.bank_sel_lo},
			(c == SPC_ACT) ? 1'b0 : p.addr[AP_BIT_POS]};
	endfunction
	function automatic logic [7:0] expc(spc_cmd_t c, logic [1:0] bk, logic ap);
		logic [3:0] ctl;
		ctl = (c == SPC_ACT) ? 4'h3 : (c == SPC_RD) ? 4'h5 : (c == SPC_WR) ? 4'h4 : (c == SPC_NOP) ? 4'hF : 4'h2;
		return {1'b0, ctl, (c == SPC_PREA || c == SPC_NOP) ? 2'h0 : bk, (c == SPC_RD || c == SPC_WR) ? ap : c == SPC_PREA};
	endfunction
	// Entered at a falling edge; valid is left up so calls run back to back
	task automatic issue(input spc_cmd_t c, input logic [1:0] bk, input logic ap, input int tries);
		tkn = 0;
		req_in = '{cmd: c, bank: bk, addr: 14'($random(seed)), auto_pre: ap};
		req_valid_in = 1;
		for (int i = 0; i < tries && !tkn; i++) begin
			#4 tkn = req_ready_out;
			@(negedge ref_clk_in);
		end
		if (tkn) chk(view(pins_out, c), expc(c, bk, ap));
		chk({4'h0, open_d}, {4'h0, mdl_open});
	endtask
	task automatic idle();
		req_valid_in = 0;
		@(negedge ref_clk_in);
	endtask
	// Clock, timeout and device-aligned copy of the open flags
	initial forever #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		open_d <= bank_open_out;
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			fail_count++;
			finish_test();
		end
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (3) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_in = 0;
		@(negedge ref_clk_in);
		issue(SPC_ACT, 1, 0, 4);
		issue(SPC_PRE, 1, 0, 12);
		issue(SPC_ACT, 1, 0, 12);
		issue(SPC_RD, 1, 0, 12);
		issue(SPC_PRE, 1, 1, 12);
		issue(SPC_ACT, 1, 0, 12);
		issue(SPC_RD, 1, 1, 12);
		issue(SPC_RD, 3, 0, 4);
		chk({7'h00, tkn}, 8'h00);
		issue(SPC_ACT, 1, 0, 20);
		issue(SPC_WR, 1, 1, 12);
		issue(SPC_ACT, 1, 0, 30);
		issue(SPC_PREA, 0, 0, 12);
		$display("test directed done");
		repeat (400) issue(spc_cmd_t'(3'($unsigned($random(seed)) % 6)), 2'($random(seed)), 1'($random(seed)), 12);
		idle();
		chk({7'h00, viol != 0}, 8'h00);
		$display("test random done");
		rst_in = 1;
		@(negedge ref_clk_in);
		rst_in = 0;
		chk({3'h0, pins_out.cs_n, bank_open_out}, 8'h10);
		@(negedge ref_clk_in);
		issue(SPC_ACT, 2, 0, 4);
		idle();
		repeat (12) @(negedge ref_clk_in);
		chk({7'h00, viol != 0}, 8'h00);
		$display("test reset done");
		finish_test();
	end
endmodule // spc_precharge_ctrl_tb
